//--- slice_lutram_srl_carry_params.svh
/*
  Constants for the slice primitive models: storage sizes, chain lengths and parameter defaults.
  Assumes it is included by its bare name from the design modules; the package does not include it.
*/
`ifndef SLICE_LUTRAM_SRL_CARRY_PARAMS_SVH
`define SLICE_LUTRAM_SRL_CARRY_PARAMS_SVH

`define RAM_DEPTH_DEFAULT 256
`define RAM_DEPTH_MIN 32
`define RAM_DEPTH_MAX 256
`define RAM_WIDE_DEPTH 32
`define RAM_WIDE_DATA_W 2
`define RAM_NARROW_DATA_W 1
`define SRL_LENGTH 32
`define SRL_ADDR_W 5
`define SRL_STAGES 4
`define CARRY_BITS 4
`define CARRY_BLOCKS_DEFAULT 2
`define CLK_INVERT_DEFAULT 1'h0

`endif

//--- slice_prims_pkg.sv
/*
  Shared types for the slice primitive models.
  Assumes the params header sits in the same folder.
*/
package slice_prims_pkg;

  // Source of the first carry of a carry chain.
  typedef enum logic [1:0] {
    INIT_ZERO,
    INIT_ONE,
    INIT_BYPASS
  } carry_init_t;

endpackage

//--- four_bit_carry_block.sv
/*
  One four-bit carry lookahead block with per-bit carries and sums.
  Assumes generate and propagate terms come from lookup-table outputs in the same clock domain.
*/
`timescale 1ns/1ps
`include "slice_lutram_srl_carry_params.svh"

module four_bit_carry_block (
  // Chain entry
  input wire logic chain_input,
  // Lookahead terms
  input wire logic [`CARRY_BITS-1:0] generate_terms,
  input wire logic [`CARRY_BITS-1:0] propagate_terms,
  // Results
  output logic [`CARRY_BITS-1:0] sum_out,
  output logic [`CARRY_BITS-1:0] carry_outs
);

  logic [`CARRY_BITS:0] carry_in;

  assign carry_in[0] = chain_input;

  for (genvar i = 0; i < `CARRY_BITS; i++) begin : g_bit
    // A set propagate term passes the incoming carry; otherwise the generate term decides.
    assign carry_outs[i] = propagate_terms[i] ? carry_in[i] : generate_terms[i]; // R19 R23
    assign sum_out[i] = propagate_terms[i] ^ carry_in[i]; // R20 R23
    assign carry_in[i+1] = carry_outs[i];
  end

endmodule // four_bit_carry_block

//--- slice_lutram_srl_carry.sv
/*
  Slice primitives: quad-port distributed RAM, a cascaded addressable shift register chain with
  wide multiplexers, and a chain of four-bit carry blocks.
  Assumes surrounding fabric logic on ref_clk drives every input and consumes every output.
*/
// Overview of operation
// R1 - Every read port works independently, all sharing one set of storage cells.
// R2 - Enabled write edge stores data at write address; disabled, nothing changes.
// R3 - Each RAM output shows its addressed cell combinationally, without a clock.
// R4 - After a write edge the read/write port shows the value just written.
// R5 - RAM write clock edge is chosen by a parameter, rising by default.
// R6 - Global set/reset leaves the RAM contents untouched.
// R7 - RAM depth 32 to 256 words; 2-bit data at depth 32, else 1 bit.
// R8 - Fourth address port reads and writes; the other three only read.
// R9 - Enabled shift loads serial input at bit 0 and moves bits up one.
// R10 - Without shift enable the shift register neither shifts nor takes data.
// R11 - Five-bit tap address picks bit 0 to 31 onto the tap output.
// R12 - Cascade output is always bit 31 and follows every shift.
// R13 - Shift register clock edge is chosen by a parameter, rising by default.
// R14 - Global set/reset leaves the shift register contents untouched.
// R15 - Length to the tap output is tap address plus one.
// R16 - Four shift registers chain through wide muxes into 128 bits.
// R17 - User registers the tap in a flop and sets address to length minus two.
// R18 - Wide mux passes first input on select 0, second on select 1.
// R19 - Carry block takes generate and propagate terms from lookup tables.
// R20 - Carry block gives one carry per bit and four sum bits.
// R21 - First carry is constant 0, constant 1 or the bypass input.
// R22 - Top carry of one block feeds the chain input of the next.
// R23 - Sum is propagate xor carry in; carry passes on propagate, else generate.
// R24 - RAM and shift contents power up to parameter values; no reset alters them.
`timescale 1ns/1ps
`include "slice_lutram_srl_carry_params.svh"

module slice_lutram_srl_carry #(
  parameter int RAM_DEPTH = `RAM_DEPTH_DEFAULT,
  parameter int CARRY_BLOCKS = `CARRY_BLOCKS_DEFAULT,
  parameter bit RAM_CLK_INVERT = `CLK_INVERT_DEFAULT,
  parameter bit SRL_CLK_INVERT = `CLK_INVERT_DEFAULT,
  parameter slice_prims_pkg::carry_init_t CARRY_INIT = slice_prims_pkg::INIT_ZERO,
  parameter int RAM_DATA_W = (RAM_DEPTH == `RAM_WIDE_DEPTH) ? `RAM_WIDE_DATA_W : `RAM_NARROW_DATA_W, // R7
  parameter int RAM_ADDR_W = $clog2(RAM_DEPTH),
  parameter logic [RAM_DEPTH*RAM_DATA_W-1:0] RAM_INIT = '0,
  parameter logic [`SRL_STAGES*`SRL_LENGTH-1:0] SRL_INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic global_set_reset,
  // Distributed RAM, read/write port
  input wire logic quad_write_strobe,
  input wire logic [RAM_ADDR_W-1:0] read_write_port_address,
  input wire logic [RAM_DATA_W-1:0] quad_write_data,
  output logic [RAM_DATA_W-1:0] read_write_port_out,
  // Distributed RAM, read-only ports
  input wire logic [RAM_ADDR_W-1:0] read_port_1_address,
  input wire logic [RAM_ADDR_W-1:0] read_port_2_address,
  input wire logic [RAM_ADDR_W-1:0] read_port_3_address,
  output logic [RAM_DATA_W-1:0] read_port_1_out,
  output logic [RAM_DATA_W-1:0] read_port_2_out,
  output logic [RAM_DATA_W-1:0] read_port_3_out,
  // Addressable shift register chain
  input wire logic shift_data_in,
  input wire logic shift_enable,
  input wire logic [`SRL_ADDR_W-1:0] tap_address,
  input wire logic [1:0] chain_select,
  output logic [`SRL_STAGES-1:0] stage_tap_out,
  output logic cascade_tap_out,
  output logic chain_tap_out,
  // Carry chain
  input wire logic bypass_input,
  input wire logic [`CARRY_BITS*CARRY_BLOCKS-1:0] generate_terms,
  input wire logic [`CARRY_BITS*CARRY_BLOCKS-1:0] propagate_terms,
  output logic [`CARRY_BITS*CARRY_BLOCKS-1:0] sum_out,
  output logic [`CARRY_BITS*CARRY_BLOCKS-1:0] carry_outs
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // State and clocks.

  typedef struct packed {
    logic [RAM_DEPTH-1:0][RAM_DATA_W-1:0] cells;
  } ram_state_t;

  typedef struct packed {
    logic [`SRL_STAGES-1:0][`SRL_LENGTH-1:0] bits;
  } srl_state_t;

  // The two primitives may run on opposite edges, so each keeps its own state word.
  ram_state_t ram_q = RAM_INIT; // R24
  ram_state_t ram_d;
  srl_state_t srl_q = SRL_INIT; // R24
  srl_state_t srl_d;

  logic ram_clk;
  logic srl_clk;
  logic [`SRL_STAGES-1:0] stage_in;
  logic [1:0] mux_low;
  logic [CARRY_BLOCKS:0] block_carry;
  logic first_carry;

  // Inverting a clock costs only an xor at the clock input; no other logic is needed.
  assign ram_clk = ref_clk ^ RAM_CLK_INVERT; // R5
  assign srl_clk = ref_clk ^ SRL_CLK_INVERT; // R13

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Distributed RAM.

  always_comb begin
    ram_d = ram_q;
    // Only the fourth port writes; global set/reset is deliberately not looked at.
    if (quad_write_strobe) begin
      ram_d.cells[read_write_port_address] = quad_write_data; // R2 R8 R6
    end
  end

  always_ff @(posedge ram_clk) begin
    ram_q <= ram_d; // R2
  end

  // All four ports read the same cells through their own address decoders.
  assign read_write_port_out = ram_q.cells[read_write_port_address]; // R3 R4
  assign read_port_1_out = ram_q.cells[read_port_1_address]; // R1 R3
  assign read_port_2_out = ram_q.cells[read_port_2_address]; // R1 R3
  assign read_port_3_out = ram_q.cells[read_port_3_address]; // R1 R3

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Addressable shift register chain.

  for (genvar k = 0; k < `SRL_STAGES; k++) begin : g_srl
    if (k == 0) begin : g_head
      assign stage_in[k] = shift_data_in;
    end else begin : g_link
      assign stage_in[k] = srl_q.bits[k-1][`SRL_LENGTH-1]; // R16
    end
    assign stage_tap_out[k] = srl_q.bits[k][tap_address]; // R11 R15
  end

  always_comb begin
    srl_d = srl_q;
    // Contents move only on an enabled edge; reset and global set/reset leave them alone.
    if (shift_enable) begin
      for (int k = 0; k < `SRL_STAGES; k++) begin
        srl_d.bits[k] = {srl_q.bits[k][`SRL_LENGTH-2:0], stage_in[k]}; // R9 R14
      end
    end
  end

  always_ff @(posedge srl_clk) begin
    srl_q <= srl_d; // R9 R10
  end

  assign cascade_tap_out = srl_q.bits[`SRL_STAGES-1][`SRL_LENGTH-1]; // R12

  // The tap is combinational; a user wanting full synchronous timing adds a flop after it.
  assign mux_low[0] = chain_select[0] ? stage_tap_out[1] : stage_tap_out[0]; // R18 R16
  assign mux_low[1] = chain_select[0] ? stage_tap_out[3] : stage_tap_out[2]; // R18 R16
  assign chain_tap_out = chain_select[1] ? mux_low[1] : mux_low[0]; // R18 R16

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Carry chain.

  always_comb begin
    unique case (CARRY_INIT)
      slice_prims_pkg::INIT_ZERO: first_carry = 1'h0; // R21
      slice_prims_pkg::INIT_ONE: first_carry = 1'h1; // R21
      slice_prims_pkg::INIT_BYPASS: first_carry = bypass_input; // R21
      default: first_carry = 1'h0;
    endcase
  end

  // The process drives its own net so that no bit of the chain vector has two kinds of driver.
  assign block_carry[0] = first_carry; // R21

  for (genvar b = 0; b < CARRY_BLOCKS; b++) begin : g_carry
    four_bit_carry_block u_carry (
      .chain_input(block_carry[b]),
      .generate_terms(generate_terms[`CARRY_BITS*b +: `CARRY_BITS]),
      .propagate_terms(propagate_terms[`CARRY_BITS*b +: `CARRY_BITS]),
      .sum_out(sum_out[`CARRY_BITS*b +: `CARRY_BITS]),
      .carry_outs(carry_outs[`CARRY_BITS*b +: `CARRY_BITS])
    );
    assign block_carry[b+1] = carry_outs[`CARRY_BITS*b + `CARRY_BITS - 1]; // R22
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on the RAM.

  chk_depth_range: assert property (@(posedge ram_clk) disable iff (!reset_n) // R7
    (RAM_DEPTH >= `RAM_DEPTH_MIN) && (RAM_DEPTH <= `RAM_DEPTH_MAX)
      && (RAM_DATA_W == ((RAM_DEPTH == `RAM_WIDE_DEPTH) ? 2 : 1)))
    else $error("RAM depth or data width out of range.");

  chk_write_readback: assert property (@(posedge ram_clk) disable iff (!reset_n) // R4
    quad_write_strobe ##1 $stable(read_write_port_address)
      |-> read_write_port_out == $past(quad_write_data))
    else $error("Read/write port does not show the value just written.");

  chk_ram_hold_idle: assert property (@(posedge ram_clk) disable iff (!reset_n) // R2
    !quad_write_strobe |=> ram_q == $past(ram_q))
    else $error("RAM changed without a write strobe.");

  chk_ram_single_cell: assert property (@(posedge ram_clk) disable iff (!reset_n) // R8
    quad_write_strobe && (read_port_1_address != read_write_port_address)
      ##1 $stable(read_port_1_address) |-> $stable(read_port_1_out))
    else $error("A write disturbed a cell other than the addressed one.");

  chk_ports_agree: assert property (@(posedge ram_clk) disable iff (!reset_n) // R1
    (read_port_2_address == read_write_port_address)
      |-> read_port_2_out == read_write_port_out)
    else $error("Two ports on the same address disagree.");

  chk_ram_gsr_immune: assert property (@(posedge ram_clk) disable iff (!reset_n) // R6
    global_set_reset && !quad_write_strobe |=> $stable(read_port_3_out) || $changed(read_port_3_address))
    else $error("Global set/reset altered the RAM.");

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on the shift register chain.

  chk_shift_load: assert property (@(posedge srl_clk) disable iff (!reset_n) // R9
    shift_enable && (tap_address == 5'h00) ##1 (tap_address == 5'h00)
      |-> stage_tap_out[0] == $past(shift_data_in))
    else $error("Serial input did not land in bit 0.");

  chk_shift_hold: assert property (@(posedge srl_clk) disable iff (!reset_n) // R10
    !shift_enable |=> srl_q == $past(srl_q))
    else $error("Shift register moved without shift enable.");

  chk_srl_gsr_immune: assert property (@(posedge srl_clk) disable iff (!reset_n) // R14
    global_set_reset && !shift_enable |=> $stable(cascade_tap_out))
    else $error("Global set/reset altered the shift register.");

  chk_cascade_follows: assert property (@(posedge srl_clk) disable iff (!reset_n) // R12
    shift_enable |=> cascade_tap_out == $past(srl_q.bits[`SRL_STAGES-1][`SRL_LENGTH-2]))
    else $error("Cascade output is not the previous bit 30 after a shift.");

  chk_tap_length: assert property (@(posedge srl_clk) disable iff (!reset_n) // R15
    (shift_enable && tap_address == 5'h02) ##1 shift_enable[*2] ##1 (tap_address == 5'h02)
      |-> stage_tap_out[0] == $past(shift_data_in, 3))
    else $error("Tap address 2 does not give a three-bit delay.");

  chk_chain_links: assert property (@(posedge srl_clk) disable iff (!reset_n) // R16
    shift_enable |=> srl_q.bits[1][0] == $past(srl_q.bits[0][`SRL_LENGTH-1]))
    else $error("Stage 1 did not take bit 31 of stage 0.");

  chk_wide_mux_sel: assert property (@(posedge srl_clk) disable iff (!reset_n) // R18
    (chain_select == 2'h2) |-> chain_tap_out == stage_tap_out[2])
    else $error("Wide mux routed the wrong stage.");

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on the carry chain.

  chk_carry_first_bit: assert property (@(posedge ref_clk) disable iff (!reset_n) // R23 R21
    sum_out[0] == (propagate_terms[0] ^ block_carry[0])
      && carry_outs[0] == (propagate_terms[0] ? block_carry[0] : generate_terms[0]))
    else $error("First carry bit does not follow its terms.");

  chk_carry_init: assert property (@(posedge ref_clk) disable iff (!reset_n) // R21
    block_carry[0] == ((CARRY_INIT == slice_prims_pkg::INIT_BYPASS) ? bypass_input
      : (CARRY_INIT == slice_prims_pkg::INIT_ONE)))
    else $error("First carry does not match the chosen source.");

  chk_carry_cascade: assert property (@(posedge ref_clk) disable iff (!reset_n) // R22
    (CARRY_BLOCKS < 2) || (propagate_terms[4] ? sum_out[4] != carry_outs[3] : 1'h1))
    else $error("Second carry block did not take the top carry of the first.");

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Scenarios worth seeing.

  cov_write_then_read: cover property (@(posedge ram_clk) disable iff (!reset_n)
    quad_write_strobe ##1 (read_port_1_address == $past(read_write_port_address)));

  cov_full_chain: cover property (@(posedge srl_clk) disable iff (!reset_n)
    shift_enable && chain_select == 2'h3 && tap_address == 5'h1F);

  cov_shift_stall: cover property (@(posedge srl_clk) disable iff (!reset_n)
    shift_enable ##1 !shift_enable ##1 shift_enable);

  cov_carry_ripple: cover property (@(posedge ref_clk) disable iff (!reset_n)
    &propagate_terms);

endmodule // slice_lutram_srl_carry

//--- fabric_user_model.sv
/*
  Fabric user model: a flop that registers the chain tap on the slice clock.
  Assumes the shift chain uses the same clock with its default rising edge.
*/
`timescale 1ns/1ps

module fabric_user_model (
  // Clock
  input wire logic ref_clk,
  // Chain tap in, registered tap out
  input wire logic tap_in,
  output logic tap_q
);
  // This flop is the last stage of the chain, so the tap address is set to length minus two.
  always_ff @(posedge ref_clk) begin
    tap_q <= tap_in;
  end
endmodule // fabric_user_model

//--- tb.sv
/*
  Self-checking bench for the slice primitives with random traffic and swept corner cases.
  Assumes default parameters on DUT: depth 256 by 1, rising edges, first carry zero.
  A second slice runs a 32 by 2 RAM and takes its first carry from the bypass input.
*/
`timescale 1ns/1ps

module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic global_set_reset = 1'b0;
  logic quad_write_strobe = 1'b0;
  logic quad_write_data = 1'b0;
  logic [7:0] rw_addr = 8'h00;
  logic [7:0] a1 = 8'h00;
  logic [7:0] a2 = 8'h00;
  logic [7:0] a3 = 8'h00;
  logic rw_out, o1, o2, o3;
  logic shift_data_in = 1'b0;
  logic shift_enable = 1'b0;
  logic [4:0] tap_address = 5'h00;
  logic [1:0] chain_select = 2'h0;
  logic [3:0] stage_tap_out, exp_tap;
  logic cascade_tap_out, chain_tap_out, tap_q, prev_chain;
  logic bypass_input = 1'b0;
  logic [7:0] gen = 8'h00;
  logic [7:0] prop = 8'h00;
  logic [7:0] sum_out, carry_outs;
  logic [7:0] sum_w, carry_w;
  logic [1:0] rw_out_w, o1_w;
  logic [1:0] mem_w [0:31];
  logic [15:0] ce;
  logic mem [0:255];
  logic [127:0] sr = '0;
  logic [31:0] r;
  integer seed = 32'h2ebed2b7;
  int errors = 0;
  int n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  slice_lutram_srl_carry DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .global_set_reset(global_set_reset),
    .quad_write_strobe(quad_write_strobe), .read_write_port_address(rw_addr),
    .quad_write_data(quad_write_data), .read_write_port_out(rw_out),
    .read_port_1_address(a1), .read_port_2_address(a2), .read_port_3_address(a3),
    .read_port_1_out(o1), .read_port_2_out(o2), .read_port_3_out(o3),
    .shift_data_in(shift_data_in), .shift_enable(shift_enable), .tap_address(tap_address),
    .chain_select(chain_select), .stage_tap_out(stage_tap_out), .cascade_tap_out(cascade_tap_out),
    .chain_tap_out(chain_tap_out), .bypass_input(bypass_input), .generate_terms(gen),
    .propagate_terms(prop), .sum_out(sum_out), .carry_outs(carry_outs)
  );

  // The bypass mode lets the first carry be driven freely; the small RAM gives two-bit words.
  slice_lutram_srl_carry #(
    .RAM_DEPTH(32),
    .CARRY_INIT(slice_prims_pkg::INIT_BYPASS)
  ) dut_bypass (
    .ref_clk(ref_clk), .reset_n(reset_n), .global_set_reset(global_set_reset),
    .quad_write_strobe(quad_write_strobe), .read_write_port_address(rw_addr[4:0]),
    .quad_write_data({shift_data_in, quad_write_data}), .read_write_port_out(rw_out_w),
    .read_port_1_address(a1[4:0]), .read_port_2_address(a2[4:0]), .read_port_3_address(a3[4:0]),
    .read_port_1_out(o1_w), .read_port_2_out(), .read_port_3_out(),
    .shift_data_in(shift_data_in), .shift_enable(shift_enable), .tap_address(tap_address),
    .chain_select(chain_select), .stage_tap_out(), .cascade_tap_out(),
    .chain_tap_out(), .bypass_input(bypass_input), .generate_terms(gen),
    .propagate_terms(prop), .sum_out(sum_w), .carry_outs(carry_w)
  );

  fabric_user_model user (.ref_clk(ref_clk), .tap_in(chain_tap_out), .tap_q(tap_q));

  ////////////////////////////////////////////////////////////////////////////////
  // Expectations and comparisons.
  function automatic logic [15:0] carry_exp(input logic [7:0] g, input logic [7:0] p, input logic c0);
    logic c;
    logic [15:0] res;
    c = c0;
    res = '0;
    for (int i = 0; i < 8; i++) begin
      res[i] = p[i] ^ c;
      c = p[i] ? c : g[i];
      res[8+i] = c;
    end
    return res;
  endfunction

  task automatic check_ram(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch ram at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic check_tap(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch shift at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic check_carry(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch carry at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence. The first 32 cycles sweep every tap, every chain select and both address ends.
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 1'b0;
    for (int i = 0; i < 32; i++) mem_w[i] = 2'h0;
    repeat (8) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 800; i++) begin
      @(posedge ref_clk);
      if (quad_write_strobe) mem[rw_addr] = quad_write_data;
      if (quad_write_strobe) mem_w[rw_addr[4:0]] = {shift_data_in, quad_write_data};
      if (shift_enable) sr = {sr[126:0], shift_data_in};
      #1;
      check_ram({1'h0, rw_out}, {1'h0, mem[rw_addr]});
      check_ram(rw_out_w, mem_w[rw_addr[4:0]]);
      if (i > 0) check_tap({3'h0, tap_q}, {3'h0, prev_chain});
      r = $random(seed);
      rw_addr = r[7:0];
      a1 = r[15:8];
      a2 = r[23:16];
      a3 = r[31:24];
      r = $random(seed);
      quad_write_strobe = r[0];
      quad_write_data = r[1];
      shift_data_in = r[2];
      shift_enable = r[3] | r[4];
      tap_address = r[9:5];
      chain_select = r[11:10];
      global_set_reset = r[12];
      bypass_input = r[13];
      gen = r[21:14];
      prop = r[29:22];
      if (i < 32) begin
        tap_address = i[4:0];
        chain_select = i[1:0];
        rw_addr = i[0] ? 8'hFF : 8'h00;
        a1 = rw_addr;
      end
      #4;
      check_ram({1'h0, rw_out}, {1'h0, mem[rw_addr]});
      check_ram({1'h0, o1}, {1'h0, mem[a1]});
      check_ram({1'h0, o2}, {1'h0, mem[a2]});
      check_ram({1'h0, o3}, {1'h0, mem[a3]});
      check_ram(rw_out_w, mem_w[rw_addr[4:0]]);
      check_ram(o1_w, mem_w[a1[4:0]]);
      for (int k = 0; k < 4; k++) exp_tap[k] = sr[32*k + tap_address];
      check_tap(stage_tap_out, exp_tap);
      check_tap({3'h0, cascade_tap_out}, {3'h0, sr[127]});
      prev_chain = sr[{chain_select, tap_address}];
      check_tap({3'h0, chain_tap_out}, {3'h0, prev_chain});
      ce = carry_exp(gen, prop, 1'b0);
      check_carry(sum_out, ce[7:0]);
      check_carry(carry_outs, ce[15:8]);
      ce = carry_exp(gen, prop, bypass_input);
      check_carry(sum_w, ce[7:0]);
      check_carry(carry_w, ce[15:8]);
    end
    stop_test();
  end

  // A run that overstays its budget is cut short and counted as a mismatch.
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule // tb
